// ---- core/mmtb_params.svh ----
/*
  Offsets, field positions and reset values for the multi-mode timer block.
  Included by the package users; holds definitions only.
*/
`ifndef MMTB_PARAMS_SVH
`define MMTB_PARAMS_SVH

`define MMTB_NUM_INST      3
`define MMTB_INST_STRIDE   12'h010
`define MMTB_OFF_CTRL      12'h000
`define MMTB_OFF_COUNT     12'h004
`define MMTB_OFF_RELOAD_A  12'h008
`define MMTB_OFF_RELOAD_B  12'h00C
`define MMTB_BIT_MODE3     7
`define MMTB_BIT_MODE2     6
`define MMTB_BIT_MODE1     5
`define MMTB_BIT_RUN       4
`define MMTB_BIT_PEND_A    3
`define MMTB_BIT_EN_A      2
`define MMTB_BIT_PEND_B    1
`define MMTB_BIT_EN_B      0
`define MMTB_CTRL_RESET    8'h00
`define MMTB_CNT_RESET     16'h0000

`endif

// ---- core/mmtb_pkg.sv ----
/*
  Types shared by the multi-mode timer block files.
  Assumes nothing of its surroundings.
*/
package mmtb_pkg;

  typedef enum logic [1:0] {
    MMTB_MODE_EVENT   = 2'b00,
    MMTB_MODE_PWM     = 2'b01,
    MMTB_MODE_CAPTURE = 2'b10
  } mmtb_mode_t;

  typedef struct packed {
    logic       mode3;
    logic       mode2;
    logic       mode1;
    logic       run;
    logic       pend_a;
    logic       en_a;
    logic       pend_b;
    logic       en_b;
  } mmtb_ctrl_t;

  typedef struct packed {
    logic        ctrl_we;
    logic [7:0]  ctrl_wdata;
    logic        cnt_we;
    logic        ra_we;
    logic        rb_we;
    logic [15:0] wdata;
  } mmtb_wr_t;

endpackage : mmtb_pkg

// ---- core/mmtb_timer.sv ----
/*
  One timer instance: down-counter, two reload/capture registers, control.
  Assumes pin inputs already synchronised to hclk and writes one cycle wide.
*/
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "mmtb_params.svh"

module mmtb_timer (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire mmtb_pkg::mmtb_wr_t wr,
  input  wire logic              pin_a_s,
  input  wire logic              pin_b_s,
  output var  mmtb_pkg::mmtb_ctrl_t ctrl,
  output var  logic [15:0]       count,
  output var  logic [15:0]       reload_a,
  output var  logic [15:0]       reload_b,
  output var  logic              pin_a_out,
  output var  logic              pin_a_oe,
  output var  logic              irq
);

  mmtb_pkg::mmtb_ctrl_t ctrl_ff;
  logic [15:0]          count_ff;
  logic [15:0]          ra_ff;
  logic [15:0]          rb_ff;
  logic                 pa_d_ff;
  logic                 pb_d_ff;
  logic                 next_b_ff;
  logic                 tog_ff;
  mmtb_pkg::mmtb_mode_t mode;
  logic                 rise_a;
  logic                 fall_a;
  logic                 rise_b;
  logic                 fall_b;
  logic                 edge_a;
  logic                 edge_b;
  logic                 dec;
  logic                 uflow;
  logic                 set_pa;
  logic                 set_pb;
  logic                 set_run;
  mmtb_pkg::mmtb_ctrl_t wv;

  always_comb begin
    if (ctrl_ff.mode2) begin
      mode = mmtb_pkg::MMTB_MODE_CAPTURE; // R3
    end else if (ctrl_ff.mode3) begin
      mode = mmtb_pkg::MMTB_MODE_PWM; // R3
    end else begin
      mode = mmtb_pkg::MMTB_MODE_EVENT; // R3
    end
  end

  assign rise_a = pin_a_s & ~pa_d_ff;
  assign fall_a = ~pin_a_s & pa_d_ff;
  assign rise_b = pin_b_s & ~pb_d_ff;
  assign fall_b = ~pin_b_s & pb_d_ff;
  assign edge_a = ctrl_ff.mode1 ? fall_a : rise_a; // R3 R16
  assign edge_b = ctrl_ff.mode3 ? fall_b : rise_b; // R16
  assign wv     = mmtb_pkg::mmtb_ctrl_t'(wr.ctrl_wdata);

  always_comb begin
    unique case (mode)
      mmtb_pkg::MMTB_MODE_PWM:     dec = ctrl_ff.run; // R4 R20
      mmtb_pkg::MMTB_MODE_EVENT:   dec = ctrl_ff.run & edge_a; // R10 R20
      mmtb_pkg::MMTB_MODE_CAPTURE: dec = 1'b1; // R14
      default:                     dec = 1'b0;
    endcase
  end

  assign uflow   = dec && (count_ff == 16'h0000); // R23
  assign set_pa  = ((mode == mmtb_pkg::MMTB_MODE_PWM) && uflow && !next_b_ff) // R7
                 || ((mode == mmtb_pkg::MMTB_MODE_EVENT) && uflow) // R11
                 || ((mode == mmtb_pkg::MMTB_MODE_CAPTURE) && edge_a); // R17
  assign set_pb  = ((mode == mmtb_pkg::MMTB_MODE_PWM) && uflow && next_b_ff) // R7
                 || ((mode == mmtb_pkg::MMTB_MODE_EVENT) && rise_b) // R12
                 || ((mode == mmtb_pkg::MMTB_MODE_CAPTURE) && edge_b); // R17
  assign set_run = (mode == mmtb_pkg::MMTB_MODE_CAPTURE) && uflow; // R18

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_d_ff <= 1'b0;
      pb_d_ff <= 1'b0;
    end else begin
      pa_d_ff <= pin_a_s;
      pb_d_ff <= pin_b_s;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= mmtb_pkg::mmtb_ctrl_t'(`MMTB_CTRL_RESET);
    end else begin
      if (wr.ctrl_we) begin
        ctrl_ff.mode3 <= wv.mode3;
        ctrl_ff.mode2 <= wv.mode2;
        ctrl_ff.mode1 <= wv.mode1;
        ctrl_ff.en_a  <= wv.en_a;
        ctrl_ff.en_b  <= wv.en_b;
      end
      ctrl_ff.pend_a <= set_pa | (wr.ctrl_we ? wv.pend_a : ctrl_ff.pend_a); // R9 R24
      ctrl_ff.pend_b <= set_pb | (wr.ctrl_we ? wv.pend_b : ctrl_ff.pend_b); // R9 R24
      ctrl_ff.run    <= set_run | (wr.ctrl_we ? wv.run : ctrl_ff.run); // R18 R24
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_b_ff <= 1'b0;
    end else if (wr.ctrl_we && wv.run && !ctrl_ff.run) begin
      next_b_ff <= 1'b0; // R5
    end else if ((mode == mmtb_pkg::MMTB_MODE_PWM) && uflow) begin
      next_b_ff <= ~next_b_ff; // R4 R5
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= `MMTB_CNT_RESET; // R22
    end else if (wr.cnt_we) begin
      count_ff <= wr.wdata;
    end else if ((mode == mmtb_pkg::MMTB_MODE_PWM) && uflow) begin
      count_ff <= next_b_ff ? rb_ff : ra_ff; // R4 R5
    end else if (dec) begin
      count_ff <= count_ff - 16'h0001; // R1 R23
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ra_ff <= `MMTB_CNT_RESET; // R22
    end else if ((mode == mmtb_pkg::MMTB_MODE_CAPTURE) && edge_a) begin
      ra_ff <= count_ff; // R15
    end else if (wr.ra_we) begin
      ra_ff <= wr.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rb_ff <= `MMTB_CNT_RESET; // R22
    end else if ((mode == mmtb_pkg::MMTB_MODE_CAPTURE) && edge_b) begin
      rb_ff <= count_ff; // R15
    end else if (wr.rb_we) begin
      rb_ff <= wr.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_ff    <= 1'b0;
      pin_a_oe  <= 1'b0;
      pin_a_out <= 1'b0;
      irq       <= 1'b0;
    end else begin
      if ((mode == mmtb_pkg::MMTB_MODE_PWM) && ctrl_ff.mode1 && uflow) begin
        tog_ff <= ~tog_ff; // R6
      end
      pin_a_oe  <= (mode == mmtb_pkg::MMTB_MODE_PWM) && ctrl_ff.mode1; // R6 R13
      pin_a_out <= tog_ff;
      irq       <= (ctrl_ff.pend_a & ctrl_ff.en_a) | (ctrl_ff.pend_b & ctrl_ff.en_b) // R8
                 | ((mode == mmtb_pkg::MMTB_MODE_CAPTURE) & ctrl_ff.run & ctrl_ff.en_a); // R18
    end
  end

  assign ctrl     = ctrl_ff;
  assign count    = count_ff;
  assign reload_a = ra_ff;
  assign reload_b = rb_ff;

endmodule : mmtb_timer
`default_nettype wire

// ---- core/mmtb_top.sv ----
/*
  Multi-mode timer block: three identical timers behind an AHB-Lite slave.
  Assumes a single-master AHB-Lite bus on hclk; timer pins are asynchronous.
*/
//
// Overview of operation
// R1: 16-bit counter plus two reload/capture registers
// R2: three identical timer instances
// R3: mode bits select event, PWM, capture
// R4: PWM counts down, alternating reloads on underflow
// R5: first reload from A, then B, A...
// R6: toggle option inverts pin A per underflow
// R7: reload from A sets pend A, B pend B
// R8: interrupt when pending and enabled
// R9: software alone clears pending flags
// R10: event mode counts selected pin A edges
// R11: event mode underflow sets pend A
// R12: event mode pin B rise sets pend B
// R13: no waveform on pin A in event mode
// R14: capture mode counts every cycle
// R15: capture copies counter on selected edges
// R16: pin A and B polarities independent
// R17: capture triggers set pend A, pend B
// R18: capture underflow sets run bit, shares A
// R19: software clears run bit entering capture
// R20: run bit starts and stops PWM/event
// R21: control byte layout mode, run, flags
// R22: counter and reloads need no power-up value
// R23: underflow when decrementing past zero
// R24: hardware set beats software clear
`timescale 1ns/1ns
`default_nettype none
`include "mmtb_params.svh"

module mmtb_top #(
  parameter int NUM_INST = `MMTB_NUM_INST
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [11:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output var  logic [31:0]         hrdata,
  output var  logic                hreadyout,
  output var  logic                hresp,
  input  wire logic [NUM_INST-1:0] pin_a_in,
  input  wire logic [NUM_INST-1:0] pin_b_in,
  output var  logic [NUM_INST-1:0] pin_a_out,
  output var  logic [NUM_INST-1:0] pin_a_oe,
  output var  logic [NUM_INST-1:0] irq
);

  logic [NUM_INST-1:0] pa_m_ff;
  logic [NUM_INST-1:0] pa_s_ff;
  logic [NUM_INST-1:0] pb_m_ff;
  logic [NUM_INST-1:0] pb_s_ff;
  logic                wpend_ff;
  logic [11:0]         waddr_ff;
  logic                rd_now;
  logic                wr_now;
  logic [31:0]         nxt_rdata;

  mmtb_pkg::mmtb_ctrl_t ctrl_v [NUM_INST];
  logic [15:0]          cnt_v  [NUM_INST];
  logic [15:0]          ra_v   [NUM_INST];
  logic [15:0]          rb_v   [NUM_INST];
  logic [NUM_INST-1:0]  pao_v;
  logic [NUM_INST-1:0]  paoe_v;
  logic [NUM_INST-1:0]  irq_v;

  function automatic logic [7:0] reg_sel(input logic [11:0] a);
    reg_sel = a[11:4];
  endfunction : reg_sel

  function automatic logic [3:0] reg_off(input logic [11:0] a);
    reg_off = a[3:0];
  endfunction : reg_off

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_now    = hsel && hready && htrans[1] && hwrite;
  assign rd_now    = hsel && hready && htrans[1] && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_m_ff <= '0;
      pa_s_ff <= '0;
      pb_m_ff <= '0;
      pb_s_ff <= '0;
    end else begin
      pa_m_ff <= pin_a_in;
      pa_s_ff <= pa_m_ff;
      pb_m_ff <= pin_b_in;
      pb_s_ff <= pb_m_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_ff <= 1'b0;
      waddr_ff <= 12'h000;
    end else begin
      wpend_ff <= wr_now;
      if (wr_now) begin
        waddr_ff <= haddr;
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h00000000;
    for (int i = 0; i < NUM_INST; i++) begin
      if (reg_sel(haddr) == 8'(i)) begin
        unique case (reg_off(haddr))
          4'h0:    nxt_rdata = {24'h000000, ctrl_v[i]}; // R21
          4'h4:    nxt_rdata = {16'h0000, cnt_v[i]};
          4'h8:    nxt_rdata = {16'h0000, ra_v[i]};
          4'hC:    nxt_rdata = {16'h0000, rb_v[i]};
          default: nxt_rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_now) begin
      hrdata <= nxt_rdata;
    end
  end

  for (genvar g = 0; g < NUM_INST; g++) begin : g_tmr
    mmtb_pkg::mmtb_wr_t wr_g;
    logic               hit;

    assign hit             = wpend_ff && (reg_sel(waddr_ff) == 8'(g));
    assign wr_g.ctrl_we    = hit && (reg_off(waddr_ff) == 4'h0);
    assign wr_g.cnt_we     = hit && (reg_off(waddr_ff) == 4'h4);
    assign wr_g.ra_we      = hit && (reg_off(waddr_ff) == 4'h8);
    assign wr_g.rb_we      = hit && (reg_off(waddr_ff) == 4'hC);
    assign wr_g.ctrl_wdata = hwdata[7:0];
    assign wr_g.wdata      = hwdata[15:0];

    mmtb_timer u_tmr ( // R2
      .hclk      (hclk),
      .hresetn   (hresetn),
      .wr        (wr_g),
      .pin_a_s   (pa_s_ff[g]),
      .pin_b_s   (pb_s_ff[g]),
      .ctrl      (ctrl_v[g]),
      .count     (cnt_v[g]),
      .reload_a  (ra_v[g]),
      .reload_b  (rb_v[g]),
      .pin_a_out (pao_v[g]),
      .pin_a_oe  (paoe_v[g]),
      .irq       (irq_v[g])
    );
  end

  assign pin_a_out = pao_v;
  assign pin_a_oe  = paoe_v;
  assign irq       = irq_v;

endmodule : mmtb_top
`default_nettype wire

// ---- dv/mmtb_sva.sv ----
/*
  Port checker for mmtb_top: bus answer, read data and pin/irq causes.
  Assumes single transfers on hclk and is bound to every mmtb_top.
*/
`timescale 1ns/1ns
`default_nettype none
module mmtb_sva #(
  parameter int NUM_INST = 3
) (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [11:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [NUM_INST-1:0] pin_a_oe,
  input wire logic [NUM_INST-1:0] irq
);
  logic       rd;
  logic [2:0] wr_hist_ff;
  assign rd = hsel & hready & htrans[1] & ~hwrite;
  // Recent write address phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wr_hist_ff <= 3'h0;
    else
      wr_hist_ff <= {wr_hist_ff[1:0], hsel & hready & htrans[1] & hwrite};
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_resp; !hresp; endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_upper; hrdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_ctrl; rd && haddr[3:0] == 4'h0 && haddr < 12'h030 |=> hrdata[31:8] == 24'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control read too wide");
  property p_unmap; rd && haddr >= 12'h030 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !rd |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed");
  property p_irq_fall; |($past(irq) & ~irq) |-> |wr_hist_ff; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
  property p_oe; pin_a_oe != $past(pin_a_oe) |-> |wr_hist_ff; endproperty
  a_oe: assert property (p_oe) else $error("pin drive changed by itself");
endmodule : mmtb_sva
bind mmtb_top mmtb_sva #(.NUM_INST(NUM_INST)) u_sva (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .pin_a_oe, .irq);
`default_nettype wire

// ---- dv/mmtb_pin_model.sv ----
/*
  Timer pin source: drives pin A and pin B of each instance.
  Assumes the bench calls drive and waits for it to return.
*/
`timescale 1ns/1ns
`default_nettype none
module mmtb_pin_model (
  input  wire logic       hclk,
  output var  logic [2:0] pin_a_in,
  output var  logic [2:0] pin_b_in
);
  initial begin
    pin_a_in = 3'h0;
    pin_b_in = 3'h0;
  end
  // Set both pin levels, then hold past the sync and edge delay
  task automatic drive(input int i, input logic a, input logic b);
    @(posedge hclk);
    pin_a_in[i] <= a;
    pin_b_in[i] <= b;
    repeat (6) @(posedge hclk);
  endtask : drive
endmodule : mmtb_pin_model
`default_nettype wire

// ---- dv/mmtb_tb_top.sv ----
/*
  Testbench for mmtb_top: AHB-Lite tasks, PWM, event and capture tests.
  Assumes the pin model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module mmtb_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  pin_a_in;
  logic [2:0]  pin_b_in;
  logic [2:0]  pin_a_out;
  logic [2:0]  pin_a_oe;
  logic [2:0]  irq;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n;
  always #2 hclk = ~hclk;
  mmtb_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_a_in, .pin_b_in, .pin_a_out,
    .pin_a_oe, .irq);
  mmtb_pin_model u_pins (.hclk, .pin_a_in, .pin_b_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  // Cycles until pin A of instance 0 next changes
  task automatic gap(output int c);
    logic p;
    p = pin_a_out[0];
    c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (pin_a_out[0] === p && c < 40);
  endtask : gap
  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 3; i++) rd(12'(i * 16), 32'h0);
    rd(12'h030, 32'h0);
    // PWM with toggle on instance 0
    wr(12'h008, 32'h3);
    wr(12'h00C, 32'h5);
    wr(12'h004, 32'h2);
    wr(12'h000, 32'hB5);
    gap(n);
    gap(n);
    chk(32'(n), 32'h4);
    gap(n);
    chk(32'(n), 32'h6);
    gap(n);
    chk(32'(n), 32'h4);
    chk(32'(pin_a_oe), 32'h1);
    chk(32'(irq), 32'h1);
    rd(12'h000, 32'hBF);
    wr(12'h000, 32'hA5);
    wr(12'h000, 32'hA5);
    rd(12'h000, 32'hA5);
    chk(32'(irq), 32'h0);
    wr(12'h000, 32'h80);
    rd(12'h000, 32'h80);
    chk(32'(pin_a_oe[0]), 32'h0);
    // Clear written in the cycle of an underflow
    wr(12'h004, 32'h2);
    wr(12'h000, 32'h94);
    wr(12'h000, 32'h94);
    rd(12'h000, 32'h9C);
    wr(12'h000, 32'h80);
    // Event counting on instance 1
    wr(12'h014, 32'h1);
    wr(12'h010, 32'h14);
    u_pins.drive(1, 1'b0, 1'b1);
    chk(32'(irq), 32'h0);
    rd(12'h010, 32'h16);
    u_pins.drive(1, 1'b1, 1'b1);
    u_pins.drive(1, 1'b0, 1'b1);
    u_pins.drive(1, 1'b1, 1'b1);
    rd(12'h010, 32'h1E);
    rd(12'h014, 32'hFFFF);
    chk(32'(irq), 32'h2);
    chk(32'(pin_a_oe[1]), 32'h0);
    wr(12'h010, 32'h34);
    u_pins.drive(1, 1'b0, 1'b1);
    rd(12'h014, 32'hFFFE);
    // Capture on instance 2
    wr(12'h024, 32'h4000);
    wr(12'h020, 32'hC5);
    u_pins.drive(2, 1'b0, 1'b1);
    rd(12'h020, 32'hC5);
    u_pins.drive(2, 1'b1, 1'b1);
    u_pins.drive(2, 1'b1, 1'b0);
    rd(12'h020, 32'hCF);
    xfer(1'b0, 12'h028, 32'h0);
    chk(q >> 8, 32'h3F);
    xfer(1'b0, 12'h02C, 32'h0);
    chk(q >> 8, 32'h3F);
    wr(12'h020, 32'hC5);
    wr(12'h024, 32'h2);
    repeat (8) @(posedge hclk);
    rd(12'h020, 32'hD5);
    chk(32'(irq[2]), 32'h1);
    // Opposite polarities, both pins at once
    wr(12'h020, 32'h64);
    u_pins.drive(2, 1'b0, 1'b1);
    rd(12'h020, 32'h6E);
    xfer(1'b0, 12'h028, 32'h0);
    chk(q >> 8, 32'hFF);
    n = int'(q);
    xfer(1'b0, 12'h02C, 32'h0);
    chk(q, 32'(n));
    finish_test();
  end
endmodule : mmtb_tb_top
`default_nettype wire
